// ### lnbsc_top.sv
`timescale 1ns/100ps
`include "lnbsc_consts.svh"
module lnbsc_top
    import lnbsc_pkg::*;
#(
    parameter int TOFF_CYC = `LNBSC_TOFF_CYC,
    parameter int TON_CYC = `LNBSC_TON_CYC,
    parameter int SOFT_CYC = `LNBSC_SOFT_CYC,
    parameter int CONV_HALF_CYC = `LNBSC_CONV_HALF_CYC
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic address_select_pin,
    input wire logic supply_good,
    input wire logic tone_gate_pin,
    input wire logic high_voltage_pin,
    input wire logic overload_detect,
    input wire logic overtemp_detect,
    output logic power_stage_on,
    output logic linear_stage_on,
    output logic vout_18v,
    output logic vout_boost_1v,
    output logic current_limit_on,
    output logic conv_clk,
    output logic tone_out,
    output logic overload_flag,
    output logic overtemp_flag
);

    // =====================================================
    // parameter check
    if (TOFF_CYC < 1 || TON_CYC < 1 || SOFT_CYC < 1) begin : g_bad_min
        $error("lnbsc_top: timer counts must be at least one");
    end
    if (TOFF_CYC >= 2**LNBSC_TIMER_W || TON_CYC >= 2**LNBSC_TIMER_W || SOFT_CYC >= 2**LNBSC_TIMER_W)
    begin : g_bad_max
        $error("lnbsc_top: timer counts exceed timer width");
    end

    // =====================================================
    // helpers
    function automatic logic addr_match(input logic [7:0] b, input logic pin);
        addr_match = (b[7:2] == `LNBSC_ADDR_UPPER) && (b[1] == pin);
    endfunction

    function automatic logic tmr_done(input logic [LNBSC_TIMER_W-1:0] c, input int lim);
        tmr_done = (c == LNBSC_TIMER_W'(lim - 1));
    endfunction

    function automatic logic [7:0] rd_byte(input lnbsc_state_t s, input logic sel);
        logic [7:0] b;
        b = `LNBSC_REG_RESET;
        if (!sel) begin
            b[`LNBSC_STC_BIT] = s.stc;
            b[`LNBSC_FRC_BIT] = s.frc;
            b[`LNBSC_BST_BIT] = s.bst;
            b[`LNBSC_VHI_BIT] = s.vhi;
            b[`LNBSC_EN_BIT] = s.en;
            b[`LNBSC_OVF_BIT] = s.ovf;
        end else begin
            b[`LNBSC_SEL_BIT] = 1'b1;
            b[`LNBSC_HOT_BIT] = s.hot;
        end
        rd_byte = b;
    endfunction

    // =====================================================
    // state
    lnbsc_state_t st;
    lnbsc_state_t nxt;

    logic scl_s;
    logic sda_s;
    logic gate_s;
    logic hv_s;
    logic addr_s;
    logic pg_s;
    logic ovl_s;
    logic ot_s;
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    logic active;
    logic [7:0] rx_byte;
    logic [7:0] ld_byte;
    logic [7:0] first_byte;

    assign scl_s = st.s2[`LNBSC_IN_SCL];
    assign sda_s = st.s2[`LNBSC_IN_SDA];
    assign gate_s = st.s2[`LNBSC_IN_GATE];
    assign hv_s = st.s2[`LNBSC_IN_HV];
    assign addr_s = st.s2[`LNBSC_IN_ADDR];
    assign pg_s = st.s2[`LNBSC_IN_PG];
    assign ovl_s = st.s2[`LNBSC_IN_OVL];
    assign ot_s = st.s2[`LNBSC_IN_OT];

    // =====================================================
    // bus conditions
    assign scl_rise = scl_s & ~st.scl_d;
    assign scl_fall = ~scl_s & st.scl_d;
    assign bus_start = scl_s & st.scl_d & st.sda_d & ~sda_s;
    assign bus_stop = scl_s & st.scl_d & ~st.sda_d & sda_s;
    assign rx_byte = {st.shift[6:0], sda_s};
    assign ld_byte = rd_byte(st, ~st.rd_sel);
    assign first_byte = rd_byte(st, 1'b0);
    assign active = st.en & ~ot_s;

    // =====================================================
    // next state
    always_comb begin
        nxt = st;
        nxt.s1 = {overtemp_detect, overload_detect, supply_good, address_select_pin,
                  high_voltage_pin, tone_gate_pin, sda_in, scl_in};
        nxt.s2 = st.s1;
        nxt.scl_d = scl_s;
        nxt.sda_d = sda_s;
        nxt.sda_out = 1'b0;

        // bus slave
        if (!pg_s) begin
            // held in lockout, register cleared, no answer
            nxt.ist = I_IDLE;
            nxt.sda_oe = 1'b0;
            nxt.bitcnt = '0;
            nxt.stc = 1'b0;
            nxt.frc = 1'b0;
            nxt.bst = 1'b0;
            nxt.vhi = 1'b0;
            nxt.en = 1'b0;
        end else if (bus_start) begin
            nxt.ist = I_RXA;
            nxt.bitcnt = '0;
            nxt.sda_oe = 1'b0;
        end else if (bus_stop) begin
            nxt.ist = I_IDLE;
            nxt.sda_oe = 1'b0;
        end else begin
            case (st.ist)
                I_IDLE: begin
                    nxt.sda_oe = 1'b0;
                end
                I_RXA: begin
                    if (scl_rise && st.bitcnt != 4'h8) begin
                        nxt.shift = rx_byte;
                        nxt.bitcnt = st.bitcnt + 1'b1;
                    end else if (scl_fall && st.bitcnt == 4'h8) begin
                        if (addr_match(st.shift, addr_s)) begin
                            nxt.rw = st.shift[0];
                            nxt.sda_oe = 1'b1;
                            nxt.ist = I_ACKA;
                        end else begin
                            nxt.ist = I_IDLE;
                        end
                    end
                end
                I_ACKA: begin
                    if (scl_fall) begin
                        nxt.bitcnt = '0;
                        if (st.rw) begin
                            // first read byte, msb driven right after ack
                            nxt.rd_sel = 1'b0;
                            nxt.tx = {first_byte[6:0], 1'b0};
                            nxt.sda_oe = ~first_byte[7];
                            nxt.bitcnt = 4'h1;
                            nxt.ist = I_TXD;
                        end else begin
                            nxt.sda_oe = 1'b0;
                            nxt.ist = I_RXD;
                        end
                    end
                end
                I_RXD: begin
                    if (scl_rise && st.bitcnt != 4'h8) begin
                        nxt.shift = rx_byte;
                        nxt.bitcnt = st.bitcnt + 1'b1;
                        if (st.bitcnt == 4'h7 && !rx_byte[`LNBSC_SEL_BIT]) begin
                            nxt.stc = rx_byte[`LNBSC_STC_BIT];
                            nxt.frc = rx_byte[`LNBSC_FRC_BIT];
                            nxt.bst = rx_byte[`LNBSC_BST_BIT];
                            nxt.vhi = rx_byte[`LNBSC_VHI_BIT];
                            nxt.en = rx_byte[`LNBSC_EN_BIT];
                        end
                    end else if (scl_fall && st.bitcnt == 4'h8) begin
                        nxt.sda_oe = 1'b1;
                        nxt.ist = I_ACKD;
                    end
                end
                I_ACKD: begin
                    if (scl_fall) begin
                        nxt.sda_oe = 1'b0;
                        nxt.bitcnt = '0;
                        nxt.ist = I_RXD;
                    end
                end
                I_TXD: begin
                    if (scl_fall) begin
                        if (st.bitcnt == 4'h8) begin
                            nxt.sda_oe = 1'b0;
                            nxt.ist = I_MACK;
                        end else begin
                            nxt.sda_oe = ~st.tx[7];
                            nxt.tx = {st.tx[6:0], 1'b0};
                            nxt.bitcnt = st.bitcnt + 1'b1;
                        end
                    end
                end
                I_MACK: begin
                    if (scl_rise) begin
                        nxt.acked = ~sda_s;
                    end else if (scl_fall) begin
                        if (st.acked) begin
                            // master ack, next byte alternates registers
                            nxt.rd_sel = ~st.rd_sel;
                            nxt.tx = {ld_byte[6:0], 1'b0};
                            nxt.sda_oe = ~ld_byte[7];
                            nxt.bitcnt = 4'h1;
                            nxt.ist = I_TXD;
                        end else begin
                            nxt.ist = I_IDLE;
                        end
                    end
                end
                default: begin
                    nxt.ist = I_IDLE;
                    nxt.sda_oe = 1'b0;
                end
            endcase
        end

        // overload protection
        nxt.tcnt = st.tcnt + 1'b1;
        if (!active) begin
            nxt.pst = P_OFF;
            nxt.ovf = 1'b0;
            nxt.tcnt = '0;
        end else begin
            case (st.pst)
                P_OFF: begin
                    nxt.pst = P_SOFT;
                    nxt.tcnt = '0;
                    nxt.ovf = 1'b0;
                end
                P_SOFT: begin
                    nxt.ovf = 1'b0;
                    if (tmr_done(st.tcnt, SOFT_CYC)) begin
                        nxt.pst = P_NORM;
                    end
                end
                P_NORM: begin
                    if (ovl_s && !st.stc) begin
                        nxt.pst = P_TOFF;
                        nxt.ovf = 1'b1;
                        nxt.tcnt = '0;
                    end else begin
                        nxt.ovf = ovl_s & st.stc;
                    end
                end
                P_TOFF: begin
                    if (tmr_done(st.tcnt, TOFF_CYC)) begin
                        nxt.pst = P_TON;
                        nxt.tcnt = '0;
                        nxt.ovl_seen = 1'b0;
                    end
                end
                P_TON: begin
                    if (ovl_s) begin
                        nxt.ovl_seen = 1'b1;
                    end
                    if (tmr_done(st.tcnt, TON_CYC)) begin
                        nxt.tcnt = '0;
                        if (st.ovl_seen || ovl_s) begin
                            nxt.pst = P_TOFF;
                        end else begin
                            nxt.pst = P_NORM;
                            nxt.ovf = 1'b0;
                        end
                    end
                end
                default: begin
                    nxt.pst = P_OFF;
                end
            endcase
        end

        // power and voltage commands
        nxt.hot = ot_s;
        nxt.pwr_on = (nxt.pst == P_SOFT) || (nxt.pst == P_NORM) || (nxt.pst == P_TON);
        nxt.lin_on = nxt.pwr_on;
        nxt.ilim = (nxt.pst == P_SOFT) || (nxt.pst == P_TON) || ((nxt.pst == P_NORM) && nxt.stc);
        nxt.v18 = nxt.pwr_on & (nxt.vhi | hv_s);
        nxt.vboost = nxt.pwr_on & nxt.bst;

        // tone source
        nxt.tone_req = nxt.pwr_on & (nxt.frc | gate_s);
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
            st.s1 <= 8'h03;
            st.s2 <= 8'h03;
            st.scl_d <= 1'b1;
            st.sda_d <= 1'b1;
            st.ist <= I_IDLE;
            st.pst <= P_OFF;
        end else begin
            st <= nxt;
        end
    end

    // =====================================================
    // tone and converter clock
    lnbsc_tone_gen #(
        .HALF_CYC(CONV_HALF_CYC),
        .MULT(`LNBSC_CONV_MULT)
    ) u_tone (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .run(st.pwr_on),
        .tone_req(st.tone_req),
        .conv_clk(conv_clk),
        .tone_out(tone_out)
    );

    // =====================================================
    // outputs
    assign sda_out = st.sda_out;
    assign sda_oe = st.sda_oe;
    assign power_stage_on = st.pwr_on;
    assign linear_stage_on = st.lin_on;
    assign vout_18v = st.v18;
    assign vout_boost_1v = st.vboost;
    assign current_limit_on = st.ilim;
    assign overload_flag = st.ovf;
    assign overtemp_flag = st.hot;

endmodule

// ### lnbsc_consts.svh
`ifndef LNBSC_CONSTS_SVH
`define LNBSC_CONSTS_SVH
// How it works
// - gate pin switches tone when not forced
// - forced tone runs continuously, pin ignored
// - converter clock is ten times tone
// - enable bit low shuts power blocks
// - select bit picks 13V or 18V
// - boost bit adds 1V to setting
// - dynamic overload: off 900ms, flag set
// - retry 20ms limited, repeat if overloaded
// - clean on interval clears flag, normal
// - static mode: flag follows overload directly
// - flag low after power-on soft-start
// - overtemperature stops power, sets flag
// - high voltage pin forces 18V output
// - sda only pulled low or released
// - sda changes only while scl low
// - start and stop seen with scl high
// - bytes are eight bits, msb first
// - addressed device acks every received byte
// - no ack while supply not good
// - address then data byte, write stores
// - address pin picks low address bit
// - supply not good clears register, idle
// - read returns registers, ack continues

// =====================================================
// timing
`define LNBSC_CLK_MHZ 250
`define LNBSC_TONE_HZ 22000
`define LNBSC_CONV_MULT 10
`define LNBSC_CONV_HALF_CYC (`LNBSC_CLK_MHZ * 1000000 / (`LNBSC_TONE_HZ * `LNBSC_CONV_MULT * 2))
`define LNBSC_TOFF_MS 900
`define LNBSC_TOFF_CYC (`LNBSC_TOFF_MS * 1000 * `LNBSC_CLK_MHZ)
`define LNBSC_TON_MS 20
`define LNBSC_TON_CYC (`LNBSC_TON_MS * 1000 * `LNBSC_CLK_MHZ)
`define LNBSC_SOFT_US 1000
`define LNBSC_SOFT_CYC (`LNBSC_SOFT_US * `LNBSC_CLK_MHZ)

// =====================================================
// bus address and register fields
`define LNBSC_ADDR_UPPER 6'h04
`define LNBSC_SEL_BIT 7
`define LNBSC_STC_BIT 6
`define LNBSC_FRC_BIT 4
`define LNBSC_BST_BIT 3
`define LNBSC_VHI_BIT 2
`define LNBSC_EN_BIT 1
`define LNBSC_OVF_BIT 0
`define LNBSC_HOT_BIT 1
`define LNBSC_REG_RESET 8'h00

// =====================================================
// positions in the input synchroniser
`define LNBSC_IN_SCL 0
`define LNBSC_IN_SDA 1
`define LNBSC_IN_GATE 2
`define LNBSC_IN_HV 3
`define LNBSC_IN_ADDR 4
`define LNBSC_IN_PG 5
`define LNBSC_IN_OVL 6
`define LNBSC_IN_OT 7
`endif

// ### lnbsc_pkg.sv
package lnbsc_pkg;

    localparam int LNBSC_TIMER_W = 28;
    localparam int LNBSC_DIV_W = 12;
    localparam int LNBSC_HALVES_W = 5;

    typedef enum logic [6:0] {
        I_IDLE = 7'b0000001,
        I_RXA = 7'b0000010,
        I_ACKA = 7'b0000100,
        I_RXD = 7'b0001000,
        I_ACKD = 7'b0010000,
        I_TXD = 7'b0100000,
        I_MACK = 7'b1000000
    } lnbsc_i2c_st_t;

    typedef enum logic [4:0] {
        P_OFF = 5'b00001,
        P_SOFT = 5'b00010,
        P_NORM = 5'b00100,
        P_TOFF = 5'b01000,
        P_TON = 5'b10000
    } lnbsc_prot_st_t;

    typedef struct packed {
        logic [7:0] s1;
        logic [7:0] s2;
        logic scl_d;
        logic sda_d;
        lnbsc_i2c_st_t ist;
        logic [3:0] bitcnt;
        logic [7:0] shift;
        logic [7:0] tx;
        logic rw;
        logic acked;
        logic rd_sel;
        logic stc;
        logic frc;
        logic bst;
        logic vhi;
        logic en;
        lnbsc_prot_st_t pst;
        logic [LNBSC_TIMER_W-1:0] tcnt;
        logic ovl_seen;
        logic ovf;
        logic hot;
        logic pwr_on;
        logic lin_on;
        logic v18;
        logic vboost;
        logic ilim;
        logic tone_req;
        logic sda_oe;
        logic sda_out;
    } lnbsc_state_t;

    typedef struct packed {
        logic [LNBSC_DIV_W-1:0] div;
        logic [LNBSC_HALVES_W-1:0] halves;
        logic conv;
        logic phase;
        logic tone;
    } lnbsc_tone_t;

endpackage

// ### lnbsc_tone_gen.sv
`timescale 1ns/100ps
`include "lnbsc_consts.svh"
module lnbsc_tone_gen
    import lnbsc_pkg::*;
#(
    parameter int HALF_CYC = `LNBSC_CONV_HALF_CYC,
    parameter int MULT = `LNBSC_CONV_MULT
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic run,
    input wire logic tone_req,
    output logic conv_clk,
    output logic tone_out
);

    // =====================================================
    // parameter check
    if (HALF_CYC < 1 || HALF_CYC >= 2**LNBSC_DIV_W || MULT < 1 || MULT >= 2**LNBSC_HALVES_W) begin : g_bad
        $error("lnbsc_tone_gen: divider parameters out of range");
    end

    // =====================================================
    // divider chain
    lnbsc_tone_t st;
    lnbsc_tone_t nxt;

    always_comb begin
        nxt = st;
        if (!run) begin
            nxt = '0;
        end else if (st.div == LNBSC_DIV_W'(HALF_CYC - 1)) begin
            nxt.div = '0;
            nxt.conv = ~st.conv;
            // tone half period spans MULT converter half periods
            if (st.halves == LNBSC_HALVES_W'(MULT - 1)) begin
                nxt.halves = '0;
                nxt.phase = ~st.phase;
            end else begin
                nxt.halves = st.halves + 1'b1;
            end
        end else begin
            nxt.div = st.div + 1'b1;
        end
        nxt.tone = run & tone_req & st.phase;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= nxt;
        end
    end

    assign conv_clk = st.conv;
    assign tone_out = st.tone;

endmodule

// ### lnbsc_top_sva.sv
`timescale 1ns/100ps
// =====================================================
// checker on the top ports
module lnbsc_chk #(
    parameter int TOFF_CYC = 200
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic scl_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic supply_good,
    input wire logic overload_detect,
    input wire logic overtemp_detect,
    input wire logic power_stage_on,
    input wire logic linear_stage_on,
    input wire logic vout_18v,
    input wire logic current_limit_on,
    input wire logic overload_flag,
    input wire logic overtemp_flag
);
    logic [31:0] off_cnt_ff;
    logic [31:0] nxt_off_cnt;
    // cycles spent with power off
    assign nxt_off_cnt = power_stage_on ? 32'h0 : off_cnt_ff + 32'h1;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            off_cnt_ff <= 32'h0;
        end else begin
            off_cnt_ff <= nxt_off_cnt;
        end
    end
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    sequence seq_ovl_hold;
        power_stage_on && !current_limit_on && overload_detect ##1 overload_detect [*5];
    endsequence
    sequence seq_retry_start;
        $rose(power_stage_on) && overload_flag;
    endsequence
    chk_sda_drive_low: assert property (sda_out == 1'b0)
        else $error("sda driven high");
    chk_sda_change_low: assert property ($changed(sda_oe) && supply_good |-> !scl_in)
        else $error("sda moved while scl high");
    chk_no_ack_unpowered: assert property (!supply_good [*6] |-> !sda_oe)
        else $error("sda pulled without supply");
    chk_power_off_unpowered: assert property (!supply_good [*8] |-> !power_stage_on && !vout_18v)
        else $error("power on without supply");
    chk_overtemp_shutdown: assert property (overtemp_detect [*6] |-> !power_stage_on && !linear_stage_on && overtemp_flag)
        else $error("overtemp not handled");
    chk_overtemp_clear: assert property (!overtemp_detect [*6] |-> !overtemp_flag)
        else $error("overtemp flag stuck");
    chk_dyn_cutoff: assert property (seq_ovl_hold |-> !power_stage_on && overload_flag)
        else $error("overload not cut off");
    chk_off_interval: assert property (seq_retry_start |-> off_cnt_ff >= 32'(TOFF_CYC - 1) && off_cnt_ff <= 32'(TOFF_CYC + 2))
        else $error("off interval length wrong");
    chk_retry_limited: assert property (seq_retry_start |-> current_limit_on)
        else $error("retry not current limited");
endmodule

bind lnbsc_top lnbsc_chk #(.TOFF_CYC(TOFF_CYC)) u_chk (
    .ref_clk(ref_clk), .rst_n(rst_n), .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .supply_good(supply_good), .overload_detect(overload_detect), .overtemp_detect(overtemp_detect),
    .power_stage_on(power_stage_on), .linear_stage_on(linear_stage_on), .vout_18v(vout_18v),
    .current_limit_on(current_limit_on), .overload_flag(overload_flag), .overtemp_flag(overtemp_flag)
);

// ### lnbsc_i2c_host.sv
`timescale 1ns/100ps
// =====================================================
// bus master model, 64 ns bit period
module lnbsc_i2c_host (
    input wire logic ref_clk,
    input wire logic sda,
    output logic scl,
    output logic m_oe
);
    initial begin
        scl = 1'b1;
        m_oe = 1'b0;
    end
    task automatic wt(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic send_start();
        m_oe <= 1'b1;
        wt(8);
        scl <= 1'b0;
    endtask
    task automatic send_stop();
        wt(2);
        m_oe <= 1'b1;
        wt(6);
        scl <= 1'b1;
        wt(8);
        m_oe <= 1'b0;
        wt(8);
    endtask
    // data moves only in the low phase
    task automatic bit_x(input logic b, output logic s);
        wt(2);
        m_oe <= !b;
        wt(6);
        scl <= 1'b1;
        wt(4);
        s = sda;
        wt(4);
        scl <= 1'b0;
    endtask
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], s);
        end
        bit_x(1'b1, s);
        ack = !s;
    endtask
    task automatic rbyte(output logic [7:0] d, input logic mack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_x(1'b1, d[i]);
        end
        bit_x(!mack, s);
    endtask
endmodule

// ### lnbsc_top_tb_top.sv
`timescale 1ns/100ps
module lnbsc_top_tb_top;
    localparam int TOFF = 200;
    localparam int TON = 50;
    localparam int SOFT = 20;
    logic ref_clk, rst_n, address_select_pin, supply_good, tone_gate_pin;
    logic high_voltage_pin, overload_detect, overtemp_detect;
    logic scl, m_oe, sda_w, sda_out, sda_oe, power_stage_on, linear_stage_on;
    logic vout_18v, vout_boost_1v, current_limit_on, conv_clk, tone_out, overload_flag, overtemp_flag;
    int n_mismatch, n_checks, n_tone, n_conv;
    // =====================================================
    // wired-and data line with pull-up
    assign sda_w = ~(m_oe | sda_oe);
    lnbsc_i2c_host host (.ref_clk(ref_clk), .sda(sda_w), .scl(scl), .m_oe(m_oe));
    lnbsc_top #(.TOFF_CYC(TOFF), .TON_CYC(TON), .SOFT_CYC(SOFT), .CONV_HALF_CYC(4)) DUT (
        .ref_clk(ref_clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out),
        .sda_oe(sda_oe), .address_select_pin(address_select_pin), .supply_good(supply_good),
        .tone_gate_pin(tone_gate_pin), .high_voltage_pin(high_voltage_pin),
        .overload_detect(overload_detect), .overtemp_detect(overtemp_detect),
        .power_stage_on(power_stage_on), .linear_stage_on(linear_stage_on), .vout_18v(vout_18v),
        .vout_boost_1v(vout_boost_1v), .current_limit_on(current_limit_on), .conv_clk(conv_clk),
        .tone_out(tone_out), .overload_flag(overload_flag), .overtemp_flag(overtemp_flag)
    );
    always @(posedge tone_out) n_tone++;
    always @(posedge conv_clk) n_conv++;
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    // =====================================================
    // shared tasks
    task automatic wt(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic aa, output logic da);
        da = 1'b0;
        host.send_start();
        host.wbyte(a, aa);
        if (aa) host.wbyte(d, da);
        host.send_stop();
    endtask
    task automatic wr_ok(input logic [7:0] d);
        logic aa, da;
        wr(8'h10, d, aa, da);
        chk({6'h00, aa, da}, 8'h03);
    endtask
    task automatic rd(output logic [7:0] b0, output logic [7:0] b1);
        logic ak;
        host.send_start();
        host.wbyte(8'h11, ak);
        chk({7'h00, ak}, 8'h01);
        host.rbyte(b0, 1'b1);
        host.rbyte(b1, 1'b0);
        host.send_stop();
    endtask
    task automatic rate(input logic [7:0] et, input logic [7:0] ec);
        int t0, c0;
        t0 = n_tone;
        c0 = n_conv;
        wt(400);
        chk(8'(n_tone - t0), et);
        chk(8'(n_conv - c0), ec);
    endtask
    // =====================================================
    // scenarios
    task automatic t_write_read();
        logic [7:0] b0, b1;
        wr_ok(8'h0E);
        wt(SOFT + 10);
        chk({5'h00, power_stage_on, linear_stage_on, vout_18v}, 8'h07);
        chk({5'h00, sda_out, vout_boost_1v, overload_flag}, 8'h02);
        rd(b0, b1);
        chk(b0, 8'h0E);
        chk(b1, 8'h80);
    endtask
    task automatic t_addr();
        logic aa, da;
        wr(8'h12, 8'h02, aa, da);
        chk({7'h00, aa}, 8'h00);
        address_select_pin <= 1'b1;
        wt(10);
        wr(8'h12, 8'h02, aa, da);
        chk({6'h00, aa, da}, 8'h03);
        wt(10);
        chk({6'h00, vout_18v, vout_boost_1v}, 8'h00);
        address_select_pin <= 1'b0;
        wt(10);
        wr(8'h14, 8'h0E, aa, da);
        chk({7'h00, aa}, 8'h00);
    endtask
    task automatic t_tone();
        rate(8'd0, 8'd50);
        tone_gate_pin <= 1'b1;
        wt(20);
        rate(8'd5, 8'd50);
        tone_gate_pin <= 1'b0;
        wr_ok(8'h12);
        wt(20);
        rate(8'd5, 8'd50);
        wr_ok(8'h02);
    endtask
    task automatic t_hv();
        high_voltage_pin <= 1'b1;
        wt(10);
        chk({7'h00, vout_18v}, 8'h01);
        high_voltage_pin <= 1'b0;
        wt(10);
        chk({7'h00, vout_18v}, 8'h00);
    endtask
    task automatic t_overload();
        overload_detect <= 1'b1;
        wt(10);
        overload_detect <= 1'b0;
        chk({6'h00, power_stage_on, overload_flag}, 8'h01);
        wt(TOFF + 5);
        chk({5'h00, power_stage_on, current_limit_on, overload_flag}, 8'h07);
        overload_detect <= 1'b1;
        wt(TON + 10);
        overload_detect <= 1'b0;
        chk({6'h00, power_stage_on, overload_flag}, 8'h01);
        wt(TOFF + TON + 20);
        chk({5'h00, power_stage_on, current_limit_on, overload_flag}, 8'h04);
        wr_ok(8'h42);
        overload_detect <= 1'b1;
        wt(8);
        chk({6'h00, power_stage_on, overload_flag}, 8'h03);
        overload_detect <= 1'b0;
        wt(8);
        chk({7'h00, overload_flag}, 8'h00);
        wr_ok(8'h02);
    endtask
    task automatic t_overtemp();
        logic [7:0] b0, b1;
        overtemp_detect <= 1'b1;
        wt(8);
        chk({5'h00, power_stage_on, linear_stage_on, overtemp_flag}, 8'h01);
        rd(b0, b1);
        chk(b1, 8'h82);
        overtemp_detect <= 1'b0;
        wt(SOFT + 10);
        chk({6'h00, power_stage_on, overtemp_flag}, 8'h02);
    endtask
    task automatic t_supply();
        logic aa, da;
        logic [7:0] b0, b1;
        supply_good <= 1'b0;
        wt(10);
        chk({7'h00, power_stage_on}, 8'h00);
        wr(8'h10, 8'h02, aa, da);
        chk({7'h00, aa}, 8'h00);
        supply_good <= 1'b1;
        wt(10);
        rd(b0, b1);
        chk(b0, 8'h00);
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        wt(60000);
        n_mismatch++;
        complete_run();
    end
    initial begin
        rst_n = 1'b0;
        address_select_pin = 1'b0;
        supply_good = 1'b1;
        tone_gate_pin = 1'b0;
        high_voltage_pin = 1'b0;
        overload_detect = 1'b0;
        overtemp_detect = 1'b0;
        n_mismatch = 0;
        n_checks = 0;
        n_tone = 0;
        n_conv = 0;
        wt(8);
        rst_n <= 1'b1;
        wt(10);
        t_write_read();
        t_addr();
        t_tone();
        t_hv();
        t_overload();
        t_overtemp();
        t_supply();
        complete_run();
    end
endmodule
